//--- core/bbid_alu.sv
`timescale 1ns/1ns
module bbid_alu
	import bbid_pkg::*;
(
	input  wire bbid_op_e   i_op,
	input  wire logic [7:0] i_work,
	input  wire logic [7:0] i_operand,
	input  wire logic [2:0] i_bit_sel,
	input  wire logic [4:0] i_flags,
	output logic      [7:0] o_result,
	output logic      [4:0] o_flags
);
	logic [8:0] sum;
	logic [4:0] nib;
	logic       cin;

	always_comb begin
		cin      = (i_op == BBID_ADDC) ? i_flags[FLAG_C] : 1'b0;
		sum      = {1'b0, i_work} + {1'b0, i_operand} + {8'h00, cin};
		nib      = {1'b0, i_work[3:0]} + {1'b0, i_operand[3:0]} + {4'h0, cin};
		o_result = i_operand;
		o_flags  = i_flags;
		case (i_op)
			BBID_ADD, BBID_ADDC: begin
				o_result         = sum[7:0];
				o_flags[FLAG_C]  = sum[8];
				o_flags[FLAG_DIGIT_CARRY] = nib[4];
				o_flags[FLAG_Z]  = (sum[7:0] == 8'h00);
				o_flags[FLAG_OVERFLOW] = (i_work[7] == i_operand[7]) && (sum[7] != i_work[7]);
				o_flags[FLAG_N]  = sum[7];
			end
			// Flags pass untouched
			BBID_TOG: begin
				o_result = i_operand ^ (8'h01 << i_bit_sel);
			end
			default: begin
				o_result = i_operand;
			end
		endcase
	end
endmodule

//--- core/bbid_decode.sv
`timescale 1ns/1ns
// How it works
// RL1 - 0010 01da adds working register to file; 0010 00da adds with carry; all flags update.
// RL2 - 0111 bbba toggles bit bbb of the file register, flags untouched.
// RL3 - Port register read as its own source uses pin levels, not latch.
// RL4 - Write back to timer zero counter clears its prescaler when assigned.
// RL5 - One instruction cycle is four oscillator periods unless the PLL runs.
// RL6 - Destination 0 writes working register, 1 writes file; access bit picks bank.
module bbid_decode
	import bbid_pkg::*;
#(
	parameter logic [7:0] TIMER_ADDR = 8'hd6,
	parameter int         PORT_COUNT = 5,
	parameter logic [7:0] PORT_BASE  = 8'h80
)
(
	input  wire logic                  i_mclk,
	input  wire logic                  i_rstn,
	input  wire logic                  i_pll_en,
	input  wire logic [15:0]           i_instr,
	input  wire logic                  i_instr_valid,
	input  wire logic [3:0]            i_bank_sel,
	input  wire logic [7:0]            i_file_rdata,
	input  wire logic [8*PORT_COUNT-1:0] i_port_pins,
	input  wire logic                  i_psa_timer,
	output logic                       o_cycle_end,
	output logic                       o_fetch,
	output logic [11:0]                o_file_addr,
	output logic                       o_file_we,
	output logic [7:0]                 o_file_wdata,
	output logic [7:0]                 o_working_register,
	output logic [4:0]                 o_flags,
	output logic                       o_prescaler_clr
);
	typedef struct packed {
		logic [1:0]  phase;
		logic [7:0]  work;
		logic [4:0]  flags;
		logic        we;
		logic [11:0] addr;
		logic [7:0]  wdata;
		logic        pclr;
	} bbid_state_s;

	bbid_state_s s_q;
	bbid_state_s s_d;
	bbid_op_e    op;
	logic [11:0] addr;
	logic [7:0]  operand;
	logic [7:0]  result;
	logic [4:0]  new_flags;
	logic        dest;
	logic        exec;

	always_comb begin
		op = BBID_NONE;
		if (i_instr[15:OPC6_LSB] == OPC_ADD_WORK_TO_FILE) begin // RL1
			op = BBID_ADD;
		end else if (i_instr[15:OPC6_LSB] == OPC_ADD_WORK_CARRY_TO_FILE) begin // RL1
			op = BBID_ADDC;
		end else if (i_instr[15:OPC4_LSB] == OPC_BIT_TOGGLE_FILE) begin // RL2
			op = BBID_TOG;
		end
	end

	// Access bit 0 is the access bank, else the selected bank
	assign addr = i_instr[ACC_BIT] ? {i_bank_sel, i_instr[7:0]}
		: {(i_instr[7] ? 4'hf : 4'h0), i_instr[7:0]}; // RL6
	assign dest = (op == BBID_TOG) ? 1'b1 : i_instr[DEST_BIT];

	always_comb begin
		operand = i_file_rdata;
		for (int p = 0; p < PORT_COUNT; p++) begin
			// Pin level, so an input driven low writes back low
			if (dest && addr == {4'hf, PORT_BASE + 8'(p)}) begin
				operand = i_port_pins[8*p +: 8]; // RL3
			end
		end
	end

	bbid_alu u_alu (
		.i_op      (op),
		.i_work    (s_q.work),
		.i_operand (operand),
		.i_bit_sel (i_instr[BITSEL_LSB +: 3]),
		.i_flags   (s_q.flags),
		.o_result  (result),
		.o_flags   (new_flags)
	);

	// PLL clocks the core directly; otherwise divide by four
	assign exec = i_pll_en || s_q.phase == PHASE_EXEC; // RL5

	always_comb begin
		s_d       = s_q;
		s_d.we    = 1'b0;
		s_d.pclr  = 1'b0;
		s_d.phase = i_pll_en ? 2'h0 : s_q.phase + 2'h1; // RL5
		if (exec && i_instr_valid && op != BBID_NONE) begin
			s_d.flags = new_flags; // RL1 RL2
			if (dest) begin
				s_d.we    = 1'b1; // RL6
				s_d.addr  = addr;
				s_d.wdata = result;
				s_d.pclr  = (addr == {4'hf, TIMER_ADDR}) && i_psa_timer; // RL4
			end else begin
				s_d.work = result; // RL6
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			s_q <= '{phase: 2'h0, work: WORK_RESET, flags: FLAGS_RESET, we: 1'b0,
				addr: 12'h000, wdata: 8'h00, pclr: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_cycle_end        = i_pll_en || s_q.phase == PHASE_LAST;
	assign o_fetch            = exec;
	assign o_file_addr        = s_q.addr;
	assign o_file_we          = s_q.we;
	assign o_file_wdata       = s_q.wdata;
	assign o_working_register = s_q.work;
	assign o_flags            = s_q.flags;
	assign o_prescaler_clr    = s_q.pclr;

	property p_cycle_four;
		@(posedge i_mclk) disable iff (!i_rstn)
		(!i_pll_en && o_cycle_end) ##1 (!i_pll_en)[*4] |-> o_cycle_end;
	endproperty
	a_cycle_four: assert property (p_cycle_four) else $error("cycle not four periods"); // RL5

	property p_gap;
		@(posedge i_mclk) disable iff (!i_rstn)
		(!i_pll_en && o_cycle_end) ##1 !i_pll_en |-> !o_cycle_end;
	endproperty
	a_gap: assert property (p_gap) else $error("cycle end too early"); // RL5

	property p_tog_flags;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op == BBID_TOG) |=> $stable(o_flags);
	endproperty
	a_tog_flags: assert property (p_tog_flags) else $error("toggle altered flags"); // RL2

	property p_tog_val;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op == BBID_TOG)
		|=> o_file_we && $countones(o_file_wdata ^ $past(operand)) == 1;
	endproperty
	a_tog_val: assert property (p_tog_val) else $error("toggle wrong"); // RL2

	property p_add;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op == BBID_ADD && dest)
		|=> o_file_wdata == 8'($past(operand) + $past(s_q.work));
	endproperty
	a_add: assert property (p_add) else $error("add result wrong"); // RL1

	property p_zero;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && (op == BBID_ADD || op == BBID_ADDC) && !dest)
		|=> o_flags[FLAG_Z] == (o_working_register == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong"); // RL1

	property p_dest_w;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op == BBID_ADD && !dest) |=> !o_file_we;
	endproperty
	a_dest_w: assert property (p_dest_w) else $error("file written for d=0"); // RL6

	property p_pclr;
		@(posedge i_mclk) disable iff (!i_rstn)
		o_prescaler_clr |-> o_file_we && o_file_addr == {4'hf, TIMER_ADDR} && $past(i_psa_timer);
	endproperty
	a_pclr: assert property (p_pclr) else $error("prescaler clear without cause"); // RL4

	property p_pin_src;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op == BBID_TOG && addr == {4'hf, PORT_BASE})
		|=> o_file_wdata[0] != $past(i_port_pins[0]) || $past(i_instr[11:9]) != 3'h0;
	endproperty
	a_pin_src: assert property (p_pin_src) else $error("port operand not from pins"); // RL3

	// Anything not executed must leave the file write, prescaler clear, working register and flags quiet
	property p_refuse;
		@(posedge i_mclk) disable iff (!i_rstn)
		!(exec && i_instr_valid && op != BBID_NONE)
		|=> !o_file_we && !o_prescaler_clr && $stable(o_working_register) && $stable(o_flags);
	endproperty
	a_refuse: assert property (p_refuse) else $error("word outside decode acted"); // RL1

	property p_pclr_cause;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op != BBID_NONE && dest && addr == {4'hf, TIMER_ADDR} && i_psa_timer)
		|=> o_prescaler_clr;
	endproperty
	a_pclr_cause: assert property (p_pclr_cause) else $error("timer write left prescaler"); // RL4

	property p_port_add;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op == BBID_ADD && dest && addr == {4'hf, PORT_BASE})
		|=> o_file_wdata == 8'($past(i_port_pins[7:0]) + $past(s_q.work));
	endproperty
	a_port_add: assert property (p_port_add) else $error("port add not from pins"); // RL3

	property p_dest_f;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op != BBID_NONE && dest)
		|=> o_file_we && o_file_addr[7:0] == $past(i_instr[7:0]) && $stable(o_working_register);
	endproperty
	a_dest_f: assert property (p_dest_f) else $error("file write missing for d=1"); // RL6

	property p_bank;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op != BBID_NONE && dest && i_instr[ACC_BIT])
		|=> o_file_addr[11:8] == $past(i_bank_sel);
	endproperty
	a_bank: assert property (p_bank) else $error("bank not from bank select"); // RL6

	property p_addc;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op == BBID_ADDC && dest)
		|=> o_file_wdata == 8'($past(operand) + $past(s_q.work) + 8'($past(s_q.flags[FLAG_C])));
	endproperty
	a_addc: assert property (p_addc) else $error("add with carry result wrong"); // RL1

	property p_carry;
		@(posedge i_mclk) disable iff (!i_rstn)
		(exec && i_instr_valid && op == BBID_ADD)
		|=> o_flags[FLAG_C] == ({1'b0, $past(operand)} + {1'b0, $past(s_q.work)} > 9'h0ff);
	endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong"); // RL1
endmodule

//--- shared/bbid_pkg.sv
package bbid_pkg;
	// Opcode fields, upper bits of the 16-bit word
	localparam logic [5:0] OPC_ADD_WORK_TO_FILE       = 6'h09;
	localparam logic [5:0] OPC_ADD_WORK_CARRY_TO_FILE = 6'h08;
	localparam logic [3:0] OPC_BIT_TOGGLE_FILE        = 4'h7;
	localparam int         OPC6_LSB                   = 10;
	localparam int         OPC4_LSB                   = 12;
	localparam int         DEST_BIT                   = 9;
	localparam int         ACC_BIT                    = 8;
	localparam int         BITSEL_LSB                 = 9;
	// Instruction cycle length in oscillator periods
	localparam int         OSC_PER_CYCLE              = 4;
	localparam logic [1:0] PHASE_LAST                 = 2'h3;
	localparam logic [1:0] PHASE_EXEC                 = 2'h2;
	localparam logic [7:0] WORK_RESET                 = 8'h00;
	localparam logic [4:0] FLAGS_RESET                = 5'h00;
	// Flag positions in the status vector
	localparam int         FLAG_C                     = 0;
	localparam int         FLAG_DIGIT_CARRY           = 1;
	localparam int         FLAG_Z                     = 2;
	localparam int         FLAG_OVERFLOW              = 3;
	localparam int         FLAG_N                     = 4;
	typedef enum logic [1:0] {BBID_NONE, BBID_ADD, BBID_ADDC, BBID_TOG} bbid_op_e;
endpackage

//--- verif/bbid_imem.sv
`timescale 1ns/1ns
module bbid_imem (
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        i_fetch,
	input  wire logic        i_load,
	input  wire logic [15:0] i_word,
	output logic      [15:0] o_instr,
	output logic             o_instr_valid
);
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_instr <= 16'hffff;
			o_instr_valid <= 1'b0;
		end else if (i_load) begin
			o_instr <= i_word;
			o_instr_valid <= 1'b1;
		end else if (i_fetch && o_instr_valid) begin
			// Word is gone once taken; show its inverse, not a stale copy
			o_instr <= ~o_instr;
			o_instr_valid <= 1'b0;
		end
	end
endmodule

//--- verif/tb_byte_bit_instruction_decode.sv
`timescale 1ns/1ns
module tb_byte_bit_instruction_decode;
	import bbid_pkg::*;
	logic        i_mclk = 1'b0;
	logic        i_rstn = 1'b0;
	logic        i_pll_en = 1'b0;
	logic [3:0]  i_bank_sel = 4'h2;
	logic [7:0]  i_file_rdata = 8'h00;
	logic [39:0] i_port_pins = 40'h5a;
	logic        i_psa_timer = 1'b0;
	logic        ld = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [15:0] instr;
	logic        vld, o_cycle_end, o_fetch, o_file_we, o_prescaler_clr;
	logic [11:0] o_file_addr;
	logic [7:0]  o_file_wdata, o_working_register;
	logic [4:0]  o_flags;
	int          n_errors = 0;
	int          samples_checked = 0;
	always #25 i_mclk = ~i_mclk;
	bbid_imem PM (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_fetch(o_fetch), .i_load(ld), .i_word(word),
		.o_instr(instr), .o_instr_valid(vld));
	bbid_decode DUT (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_pll_en(i_pll_en), .i_instr(instr),
		.i_instr_valid(vld), .i_bank_sel(i_bank_sel), .i_file_rdata(i_file_rdata),
		.i_port_pins(i_port_pins), .i_psa_timer(i_psa_timer), .o_cycle_end(o_cycle_end),
		.o_fetch(o_fetch), .o_file_addr(o_file_addr), .o_file_we(o_file_we),
		.o_file_wdata(o_file_wdata), .o_working_register(o_working_register), .o_flags(o_flags),
		.o_prescaler_clr(o_prescaler_clr));
	task automatic conclude();
		if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Issue one word; returns just after the edge that took it
	task automatic ex(input logic [15:0] w, input logic [7:0] rd);
		@(posedge i_mclk);
		#1;
		word = w;
		i_file_rdata = rd;
		ld = 1'b1;
		@(posedge i_mclk);
		#1;
		ld = 1'b0;
		for (int k = 0; k < 8 && vld === 1'b1; k++) begin
			@(posedge i_mclk);
			#1;
		end
	endtask
	task automatic t_add();
		ex(16'h2510, 8'h35);
		chk(o_working_register, 12'h035);
		chk(o_file_we, 12'h0);
		ex(16'h2680, 8'h00);
		chk(o_file_addr, 12'hf80);
		chk(o_file_wdata, 12'h08f);
		chk(o_flags, 12'h018);
		chk(o_file_we, 12'h1);
	endtask
	task automatic t_addc();
		ex(16'h2511, 8'hff);
		chk(o_flags, 12'h003);
		ex(16'h2340, 8'hcb);
		chk(o_file_addr, 12'h240);
		chk(o_file_wdata, 12'h000);
		chk(o_flags, 12'h007);
	endtask
	task automatic t_tog();
		ex(16'h7b20, 8'h0f);
		chk(o_file_addr, 12'h220);
		chk(o_file_wdata, 12'h02f);
		chk(o_flags, 12'h007);
		ex(16'h0000, 8'h77);
		chk(o_file_we, 12'h0);
		chk(o_working_register, 12'h034);
	endtask
	task automatic t_tmr();
		i_psa_timer = 1'b1;
		ex(16'h26d6, 8'h10);
		chk(o_file_addr, 12'hfd6);
		chk(o_prescaler_clr, 12'h1);
		i_psa_timer = 1'b0;
		ex(16'h70d6, 8'h44);
		chk(o_file_wdata, 12'h045);
		chk(o_prescaler_clr, 12'h0);
	endtask
	// Pin operand, access bank and selected bank
	task automatic t_port();
		ex(16'h7080, 8'hff);
		chk(o_file_addr, 12'hf80);
		chk(o_file_wdata, 12'h05b);
		chk(o_flags, 12'h000);
		i_psa_timer = 1'b1;
		ex(16'h24d6, 8'h0c);
		chk(o_prescaler_clr, 12'h0);
		chk(o_working_register, 12'h040);
		chk(o_flags, 12'h002);
		i_psa_timer = 1'b0;
		i_bank_sel = 4'h5;
		ex(16'h2733, 8'h11);
		chk(o_file_addr, 12'h533);
		chk(o_file_wdata, 12'h051);
		ex(16'h2633, 8'h01);
		chk(o_file_addr, 12'h033);
		chk(o_file_wdata, 12'h041);
	endtask
	// Spacing of execute strobes, in clocks
	task automatic t_cyc(input logic pll, input int exp);
		int n;
		i_pll_en = pll;
		@(negedge i_mclk);
		for (int k = 0; k < 8 && o_fetch !== 1'b1; k++) @(negedge i_mclk);
		chk(o_cycle_end, {11'h000, pll});
		n = 0;
		do begin
			@(negedge i_mclk);
			n++;
			if (n == 1) chk(o_cycle_end, 12'h001);
		end while (o_fetch !== 1'b1 && n < 8);
		chk(n[11:0], exp[11:0]);
	endtask
	initial begin
		#200000;
		n_errors++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge i_mclk);
		#1;
		i_rstn = 1'b1;
		t_add();
		t_addc();
		t_tog();
		t_tmr();
		t_port();
		t_cyc(1'b0, OSC_PER_CYCLE);
		t_cyc(1'b1, 1);
		conclude();
	end
endmodule
